/* File: hdl/dais_pkg.sv */
// Shared constants, modes and carriers of the drum analog I/O scheduler.
package dais_pkg;
   // Field widths.
   localparam int WORD_W = 20;
   localparam int SECT_W = 7;
   localparam int SET_W = 5;
   localparam int TRK_W = 3;
   localparam int GATE_W = 5;
   localparam int CHAN_W = 6;
   localparam int REV_W = 4;
   // Values after reset, and the last relay set.
   localparam logic [SECT_W-1:0] SECT_RESET = 7'h00;
   localparam logic [SET_W-1:0] SET_RESET = 5'h00;
   localparam logic [REV_W-1:0] REV_RESET = 4'h0;
   localparam logic [WORD_W-1:0] WORD_RESET = 20'h00000;
   localparam logic [SET_W-1:0] SET_LAST = 5'h1F;
   // Settling revolutions for a 2, 3 or 4 stage revolution counter.
   localparam logic [REV_W-1:0] SETTLE_2 = 4'h2;
   localparam logic [REV_W-1:0] SETTLE_6 = 4'h6;
   localparam logic [REV_W-1:0] SETTLE_14 = 4'hE;
   // Full scan of all inputs, seconds, for the three counter widths.
   localparam real SCAN_S_2 = 2.13;
   localparam real SCAN_S_6 = 4.26;
   localparam real SCAN_S_14 = 8.53;
   // Gate and track option: 4/1, 8/2, 16/4 or 32/8.
   typedef enum logic [1:0] {
      DAIS_GATES_4 = 2'b00,
      DAIS_GATES_8 = 2'b01,
      DAIS_GATES_16 = 2'b10,
      DAIS_GATES_32 = 2'b11
   } dais_opt_type;
   // Revolution counter width.
   typedef enum logic [1:0] {
      DAIS_RCW_2 = 2'b00,
      DAIS_RCW_3 = 2'b01,
      DAIS_RCW_4 = 2'b10
   } dais_rcw_type;
   // Phase of the input cycle.
   typedef enum logic [1:0] {
      DAIS_CY_FIRST = 2'b00,
      DAIS_CY_SETTLE = 2'b01,
      DAIS_CY_LAST = 2'b10
   } dais_cycle_type;
   // One input sample to be written on the drum.
   typedef struct packed {
      logic [TRK_W-1:0] track;
      logic [SECT_W-1:0] sector;
      logic [WORD_W-1:0] data;
   } dais_rec_type;
   // One output conversion.
   typedef struct packed {
      logic [CHAN_W-1:0] channel;
      logic [WORD_W-1:0] data;
   } dais_da_type;
endpackage

/* File: hdl/dais_core.sv */
// Converter timing and placement control for analog inputs and outputs.
`timescale 1ns/1ns
// Behaviour
// - Every even sector without an input sample starts an output conversion by reading its word.
// - All 64 output slots not taken by an input sample convert whether or not hardware is fitted.
// - Revolutions are counted after relay switching to let inputs settle.
// - Settling lasts 14, 6 or 2 revolutions plus first and last one.
// - Counter width sets only the idle time, not conversion sequencing.
// - Full scan takes 2.13, 4.26 or 8.53 seconds by counter width.
// - Up to 32 gate groups of 32 relay sets, 1024 inputs.
// - Four gates: sectors 32 apart, advancing one per last revolution.
// - Eight gates: sectors 16 apart, first track filled before second.
// - 32 gates: sectors four apart, track full after four cycles.
// - All relay sets are always stepped and presented for recording.
// - Exactly four options: 4, 8, 16 or 32 gates on 1-8 tracks.
// - Slots of absent groups are still converted and written.
// - Compensation resistor released only during the output servo time.
// - Sample when relay count matches low sector bits; high bits pick gate.
// - Samples only in last revolution; select word one, record word two.
// - An input command clears a held output word and proceeds.
module dais_core
   import dais_pkg::*;
(
   input wire logic clock_in,
   input wire logic reset_in,
   input wire dais_opt_type gate_option_in,
   input wire dais_rcw_type counter_width_in,
   input wire logic sector_mark_in,
   input wire logic index_mark_in,
   input wire logic [WORD_W-1:0] adc_word_in,
   input wire logic [WORD_W-1:0] dac_word_in,
   output logic [SET_W-1:0] relay_set_out,
   output logic relay_switch_out,
   output dais_cycle_type cycle_phase_out,
   output logic [SECT_W-1:0] sector_out,
   output logic [GATE_W-1:0] gate_select_out,
   output logic gate_close_out,
   output logic ad_start_out,
   output logic record_valid_out,
   output dais_rec_type record_out,
   output logic da_start_out,
   output dais_da_type da_out,
   output logic comp_release_out,
   output logic conv_clear_out,
   output logic scan_done_out
);

   // Number of low sector bits compared with the relay set count.
   // static option decode.
   function automatic int cmp_bits(input dais_opt_type opt);
      case (opt)
         DAIS_GATES_4: cmp_bits = 5;
         DAIS_GATES_8: cmp_bits = 4;
         DAIS_GATES_16: cmp_bits = 3;
         default: cmp_bits = 2;
      endcase
   endfunction

   // Settling revolutions for the fitted revolution counter width.
   function automatic logic [REV_W-1:0] settle_revs(input dais_rcw_type w);
      case (w)
         DAIS_RCW_2: settle_revs = SETTLE_2;
         DAIS_RCW_3: settle_revs = SETTLE_6;
         default: settle_revs = SETTLE_14;
      endcase
   endfunction

   logic sect_s1_q, sect_s2_q, sect_s3_q;
   logic idx_s1_q, idx_s2_q;
   logic [WORD_W-1:0] adc_s1_q, adc_s2_q;
   logic [WORD_W-1:0] dac_s1_q, dac_s2_q;
   logic sect_tick;
   logic [SECT_W-1:0] sect_q, sect_d;
   dais_cycle_type cy_q, cy_d;
   logic [REV_W-1:0] rev_q, rev_d;
   logic [SET_W-1:0] set_q;
   logic cycle_end;
   logic [SECT_W-1:0] mask;
   logic sample_now;
   logic rec_pend_q;
   logic [TRK_W-1:0] rec_trk_q;
   logic [SECT_W-1:0] rec_sect_q;
   logic da_loaded_q;
   logic [WORD_W-1:0] da_buf_q;
   logic [CHAN_W-1:0] da_chan_q;
   logic servo_q;
   logic [GATE_W-1:0] gate_q;
   logic gate_close_q;
   logic ad_start_q;
   logic rec_valid_q;
   dais_rec_type rec_q;
   logic da_start_q;
   dais_da_type da_q;
   logic clear_q;
   logic switch_q;
   logic done_q;

   // Drum mark inputs pass two flip-flops before any logic reads them.
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         sect_s1_q <= 1'b0;
         sect_s2_q <= 1'b0;
         sect_s3_q <= 1'b0;
         idx_s1_q <= 1'b0;
         idx_s2_q <= 1'b0;
      end else begin
         sect_s1_q <= sector_mark_in;
         sect_s2_q <= sect_s1_q;
         sect_s3_q <= sect_s2_q;
         idx_s1_q <= index_mark_in;
         idx_s2_q <= idx_s1_q;
      end
   end

   // Converter and output track data are synchronised the same way.
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         adc_s1_q <= WORD_RESET;
         adc_s2_q <= WORD_RESET;
         dac_s1_q <= WORD_RESET;
         dac_s2_q <= WORD_RESET;
      end else begin
         adc_s1_q <= adc_word_in;
         adc_s2_q <= adc_s1_q;
         dac_s1_q <= dac_word_in;
         dac_s2_q <= dac_s1_q;
      end
   end

   // A rising sector mark opens a new word time.
   assign sect_tick = sect_s2_q & ~sect_s3_q;

   // Sector counter; the index mark returns it to sector zero.
   always_comb begin
      sect_d = sect_q;
      if (sect_tick) begin
         if (idx_s2_q) begin
            sect_d = SECT_RESET;
         end else begin
            sect_d = sect_q + 7'h01;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         sect_q <= SECT_RESET;
      end else begin
         sect_q <= sect_d;
      end
   end

   // Input cycle sequencing, one step per revolution.
   always_comb begin
      cy_d = cy_q;
      rev_d = rev_q;
      cycle_end = 1'b0;
      if (sect_tick && idx_s2_q) begin
         case (cy_q)
            DAIS_CY_FIRST: begin
               cy_d = DAIS_CY_SETTLE;
               rev_d = REV_RESET;
            end
            DAIS_CY_SETTLE: begin
               rev_d = rev_q + 4'h1;
               if (rev_q == settle_revs(counter_width_in) - 4'h1) begin
                  cy_d = DAIS_CY_LAST;
               end
            end
            default: begin
               cy_d = DAIS_CY_FIRST;
               cycle_end = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         cy_q <= DAIS_CY_FIRST;
         rev_q <= REV_RESET;
      end else begin
         cy_q <= cy_d;
         rev_q <= rev_d;
      end
   end

   // Relay set counter steps to the next set after every last revolution.
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         set_q <= SET_RESET;
         switch_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         switch_q <= cycle_end;
         done_q <= cycle_end && (set_q == SET_LAST);
         if (cycle_end) begin
            set_q <= set_q + 5'h01;
         end
      end
   end

   assign mask = SECT_W'((1 << cmp_bits(gate_option_in)) - 1);

   // sample in the last revolution on a match.
   assign sample_now = sect_tick && (cy_d == DAIS_CY_LAST) &&
      (((sect_d ^ {2'b00, set_q}) & mask) == SECT_RESET);

   // First word time: close the voltage gate and start the conversion.
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         gate_q <= 5'h00;
         gate_close_q <= 1'b0;
         ad_start_q <= 1'b0;
         rec_pend_q <= 1'b0;
         rec_trk_q <= 3'h0;
         rec_sect_q <= SECT_RESET;
      end else begin
         ad_start_q <= sample_now;
         if (sect_tick) begin
            gate_close_q <= sample_now;
            rec_pend_q <= sample_now;
         end
         if (sample_now) begin
            gate_q <= GATE_W'(sect_d >> cmp_bits(gate_option_in));
            rec_trk_q <= TRK_W'(set_q >> cmp_bits(gate_option_in));
            rec_sect_q <= sect_d;
         end
      end
   end

   // Second word time: hand the converted word to the drum write logic.
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         rec_valid_q <= 1'b0;
         rec_q <= '0;
      end else begin
         rec_valid_q <= sect_tick && rec_pend_q;
         if (sect_tick && rec_pend_q) begin
            rec_q.track <= rec_trk_q;
            rec_q.sector <= rec_sect_q;
            rec_q.data <= adc_s2_q;
         end
      end
   end

   // Output words are read on even sectors and converted on odd ones.
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         da_loaded_q <= 1'b0;
         da_buf_q <= WORD_RESET;
         da_chan_q <= 6'h00;
         da_start_q <= 1'b0;
         da_q <= '0;
         clear_q <= 1'b0;
      end else begin
         da_start_q <= 1'b0;
         clear_q <= 1'b0;
         if (sect_tick && !sect_d[0] && !sample_now) begin
            da_buf_q <= dac_s2_q;
            da_chan_q <= sect_d[SECT_W-1:1];
            da_loaded_q <= 1'b1;
         end else if (sect_tick && da_loaded_q && sample_now) begin
            da_buf_q <= WORD_RESET;
            da_loaded_q <= 1'b0;
            clear_q <= 1'b1;
         end else if (sect_tick && da_loaded_q) begin
            da_start_q <= 1'b1;
            da_q.channel <= da_chan_q;
            da_q.data <= da_buf_q;
            da_loaded_q <= 1'b0;
         end
      end
   end

   // Servo time lasts the whole conversion word.
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         servo_q <= 1'b0;
      end else if (sect_tick) begin
         servo_q <= da_loaded_q && sect_d[0] && !sample_now;
      end
   end

   assign relay_set_out = set_q;
   assign relay_switch_out = switch_q;
   assign cycle_phase_out = cy_q;
   assign sector_out = sect_q;
   assign gate_select_out = gate_q;
   assign gate_close_out = gate_close_q;
   assign ad_start_out = ad_start_q;
   assign record_valid_out = rec_valid_q;
   assign record_out = rec_q;
   assign da_start_out = da_start_q;
   assign da_out = da_q;
   assign comp_release_out = servo_q;
   assign conv_clear_out = clear_q;
   assign scan_done_out = done_q;

endmodule

/* File: dv/dais_drum_model.sv */
// Drum mark source for the scheduler bench.
`timescale 1ns/1ns
module dais_drum_model (
   input wire logic clock_in,
   input wire logic run_in,
   output logic sector_mark_out,
   output logic index_mark_out,
   output logic [6:0] word_out
);
   logic [2:0] ph_q;
   logic [6:0] sect_q;
   initial begin
      sector_mark_out = 1'b0;
      index_mark_out = 1'b0;
   end
   // Eight clocks a word, mark high four; index rides sector zero.
   always @(posedge clock_in) begin
      #1;
      if (!run_in) begin
         ph_q = 3'h0;
         sect_q = 7'h7F;
      end else begin
         if (ph_q == 3'h0) sect_q = sect_q + 7'h01;
         ph_q = ph_q + 3'h1;
      end
      sector_mark_out = run_in && ph_q >= 3'h1 && ph_q <= 3'h4;
      index_mark_out = sector_mark_out && sect_q == 7'h00;
      word_out = sector_mark_out ? sect_q : sect_q + 7'h01;
   end
endmodule

/* File: dv/dais_core_asserts.sv */
// Timing checks on the scheduler ports.
`timescale 1ns/1ns
module dais_core_asserts
   import dais_pkg::*;
(
   input wire logic clock_in,
   input wire logic reset_in,
   input wire dais_opt_type gate_option_in,
   input wire logic [SET_W-1:0] relay_set_out,
   input wire logic relay_switch_out,
   input wire dais_cycle_type cycle_phase_out,
   input wire logic [SECT_W-1:0] sector_out,
   input wire logic [GATE_W-1:0] gate_select_out,
   input wire logic gate_close_out,
   input wire logic ad_start_out,
   input wire logic record_valid_out,
   input wire dais_rec_type record_out,
   input wire logic da_start_out,
   input wire dais_da_type da_out,
   input wire logic comp_release_out,
   input wire logic conv_clear_out,
   input wire logic scan_done_out
);
   logic [2:0] k;
   assign k = 3'h5 - {1'b0, gate_option_in};
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (reset_in);
   property p_da;
      da_start_out |-> sector_out[0] && comp_release_out
         && da_out.channel == sector_out[6:1];
   endproperty
   a_da: assert property (p_da) else $error("bad output start");
   property p_last;
      ad_start_out |-> cycle_phase_out == DAIS_CY_LAST && gate_close_out;
   endproperty
   a_last: assert property (p_last) else $error("sample off last");
   property p_hold;
      $rose(gate_close_out) |-> ad_start_out
         ##1 (!ad_start_out && gate_close_out);
   endproperty
   a_hold: assert property (p_hold) else $error("gate timing");
   property p_gate;
      ad_start_out |-> gate_select_out == sector_out >> k;
   endproperty
   a_gate: assert property (p_gate) else $error("wrong gate");
   property p_place;
      ad_start_out |-> ((sector_out[4:0] ^ relay_set_out)
         & (5'h1F >> gate_option_in)) == 5'h00;
   endproperty
   a_place: assert property (p_place) else $error("wrong sector");
   property p_track;
      record_valid_out && record_out.sector != 7'h7F |->
         record_out.sector == sector_out - 7'h01
         && record_out.track == relay_set_out >> k;
   endproperty
   a_track: assert property (p_track) else $error("wrong track");
   property p_comp;
      comp_release_out |-> sector_out[0] && !gate_close_out;
   endproperty
   a_comp: assert property (p_comp) else $error("servo off odd");
   property p_clear;
      conv_clear_out |-> sector_out[0] && gate_close_out && !da_start_out;
   endproperty
   a_clear: assert property (p_clear) else $error("bad clear");
   property p_relay;
      relay_switch_out |-> cycle_phase_out == DAIS_CY_FIRST;
   endproperty
   a_relay: assert property (p_relay) else $error("relay step");
   property p_done;
      scan_done_out |-> relay_switch_out && relay_set_out == 5'h00;
   endproperty
   a_done: assert property (p_done) else $error("scan end");
   c_rec: cover property (record_valid_out);
   c_da: cover property (da_start_out);
   c_clr: cover property (conv_clear_out);
endmodule
bind dais_core dais_core_asserts u_chk (.clock_in, .reset_in,
   .gate_option_in, .relay_set_out, .relay_switch_out, .cycle_phase_out,
   .sector_out, .gate_select_out, .gate_close_out, .ad_start_out,
   .record_valid_out, .record_out, .da_start_out, .da_out,
   .comp_release_out, .conv_clear_out, .scan_done_out);

/* File: dv/drum_analog_io_scheduler_bench.sv */
// Scoreboard bench for the scheduler against a drum mark model.
`timescale 1ns/1ns
module drum_analog_io_scheduler_bench
   import dais_pkg::*;
;
   logic clock_in = 1'b0;
   logic reset_in = 1'b1;
   logic run = 1'b0;
   dais_opt_type opt = DAIS_GATES_4;
   dais_rcw_type rcw = DAIS_RCW_2;
   logic sector_mark_in, index_mark_in, relay_switch_out, gate_close_out;
   logic ad_start_out, record_valid_out, da_start_out, comp_release_out;
   logic conv_clear_out, scan_done_out;
   logic [6:0] word, sector_out, ps;
   logic [4:0] relay_set_out, gate_select_out;
   dais_cycle_type cycle_phase_out;
   dais_rec_type record_out;
   dais_da_type da_out;
   logic [19:0] adc_t [128];
   logic [19:0] dac_t [128];
   logic [31:0] exp_q [$];
   logic [31:0] rng = 32'h1A41C16F;
   int err_total = 0, checks = 0, cyc = 0, rev = 0, settle = 2, pr;
   always #5 clock_in = ~clock_in;
   dais_drum_model u_drum (.clock_in, .run_in(run),
      .sector_mark_out(sector_mark_in), .index_mark_out(index_mark_in),
      .word_out(word));
   dais_core DUT (.clock_in, .reset_in, .gate_option_in(opt),
      .counter_width_in(rcw), .sector_mark_in, .index_mark_in,
      .adc_word_in(adc_t[word]), .dac_word_in(dac_t[word]), .relay_set_out,
      .relay_switch_out, .cycle_phase_out, .sector_out, .gate_select_out,
      .gate_close_out, .ad_start_out, .record_valid_out, .record_out,
      .da_start_out, .da_out, .comp_release_out, .conv_clear_out,
      .scan_done_out);
   function automatic logic [19:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng[19:0];
   endfunction
   // True when sector s of revolution rr holds an input sample.
   function automatic logic samp(input logic [6:0] s, input int rr);
      int l;
      l = settle + 2;
      return rr > 0 && rr % l == l - 1
         && ((s[4:0] ^ 5'((rr / l) % 32)) & (5'h1F >> opt)) == 5'h00;
   endfunction
   task automatic test_done();
      if (err_total == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic got(input logic [31:0] v);
      logic [31:0] e;
      checks++;
      e = exp_q.size() > 0 ? exp_q.pop_front() : 32'hFFFFFFFF;
      if (e !== v) begin
         err_total++;
         $display("[ERR] %0t exp %h got %h", $time, e, v);
      end
   endtask
   // expected events, noted as each word opens.
   always @(posedge sector_mark_in) begin
      if (word == 7'h00) rev++;
      pr = word == 7'h00 ? rev - 1 : rev;
      ps = word - 7'h01;
      if (samp(ps, pr))
         exp_q.push_back({2'h1, 3'((pr / (settle + 2)) % 32 >> (5 - opt)),
            ps, adc_t[word]});
      else if (word[0] && !samp(word, rev))
         exp_q.push_back({2'h2, 4'h0, ps[6:1], dac_t[ps]});
      else if (word[0])
         exp_q.push_back({2'h3, 30'h0});
   end
   // Result events are compared against the oldest note.
   always @(negedge clock_in) begin
      if (record_valid_out === 1'b1) got({2'h1, record_out});
      if (da_start_out === 1'b1) got({2'h2, 4'h0, da_out});
      if (conv_clear_out === 1'b1) got({2'h3, 30'h0});
      if (scan_done_out === 1'b1) got({2'h0, 30'h0});
   end
   // Hang guard over the whole run.
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 90000) begin
         err_total++;
         test_done();
      end
   end
   // every option, static setting, two or six input cycles.
   initial begin
      for (int o = 0; o < 4; o++) begin
         @(posedge clock_in);
         #1;
         reset_in = 1'b1;
         opt = dais_opt_type'(o);
         rcw = dais_rcw_type'(o % 3);
         settle = o % 3 == 0 ? 2 : o % 3 == 1 ? 6 : 14;
         rev = 0;
         for (int i = 0; i < 128; i++) begin
            adc_t[i] = rnd();
            dac_t[i] = rnd();
         end
         repeat (10) @(posedge clock_in);
         #1;
         reset_in = 1'b0;
         run = 1'b1;
         // Six cycles on 32 gates reach relay sets on the second track.
         repeat ((settle + 2) * (o == 3 ? 6 : 2) * 1024 + 8)
            @(posedge clock_in);
         #1;
         run = 1'b0;
         repeat (20) @(posedge clock_in);
         checks++;
         if (exp_q.size() != 0) begin
            err_total++;
            $display("[ERR] %0t exp %h got %h", $time, 0, exp_q.size());
         end
      end
      test_done();
   end
endmodule
